// ### rtl/chop_top.sv
// Purpose: decay control and driver diagnostics for two coils, AHB-Lite registers
// Assumes: all pin inputs synchronous to hclk; single-word transfers only
// Notes: one wait state on every access; interrupts are sticky, write one to clear
//
// Notes on behaviour
// - mode select 1 runs the constant off-time chopper.
// - mode select 0 picks hysteresis chopper, 1 the constant off-time one.
// - in constant off-time mode, each on phase ended by comparator is followed by fixed fast decay.
// - fast decay length is top bit plus start bits; zero means slow only.
// - comparator may end fast decay early unless its disable bit is set.
// - fullstep under load-dependent speed control forces constant off-time.
// - both coil choppers run independently, unsynchronised.
// - random enable modulates slow decay time from a pseudo-random generator.
// - pre-warning and shutdown temperature flags are provided.
// - after shutdown the driver stays off until pre-warning clears.
// - short detection retries three times before switching off.
// - a confirmed short turns off only that coil and sets its flag.
// - short latch-off ends only by disabling then re-enabling the driver.
// - open-load flag sets when coil current cannot reach its target.
// - open-load flags are information only, no driver action.
// - open load is not judged during standstill.
`timescale 1ns/1ps
`include "chop_map.svh"
module chop_top
    import chop_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic temp_prewarn,
    input wire logic temp_shutdown,
    input wire logic fullstep_load_mode,
    input wire logic motor_standstill,
    input wire coil_in_t coil_a_in,
    input wire coil_in_t coil_b_in,
    output coil_out_t coil_a_out,
    output coil_out_t coil_b_out,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    top_state_t s_q;
    top_state_t s_d;
    diag_t diag;
    logic [5:0] ev_now;
    logic [5:0] ev_rise;
    logic [5:0] w1c;
    logic [7:0] rnd;
    logic [3:0] rnd_a;
    logic [3:0] rnd_b;
    logic const_off;
    logic run;
    logic [3:0] fast_len;
    logic addr_phase;

    ////////////////////////////////////////////////////////////////////////
    // chopper configuration

    // fullstep load-dependent mode overrides the mode bit
    assign const_off = s_q.ctrl.mode_sel || fullstep_load_mode;

    // fast decay length joins the top bit and the start field
    assign fast_len = {s_q.ctrl.fast_decay_top_bit, s_q.ctrl.hyst_start_field};

    // zero off time also keeps the bridges off, as a safe idle setting
    assign run = s_q.ctrl.drv_en && !s_q.hot_latch && s_q.ctrl.slow_decay_time != 4'h0;

    // separate nibbles so the coils do not beat in step
    assign rnd_a = s_q.ctrl.rand_en ? rnd[3:0] : 4'h0;
    assign rnd_b = s_q.ctrl.rand_en ? rnd[7:4] : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // random source and coil sequencers

    rand_lfsr u_rand
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .rnd(rnd)
    );

    // each coil has its own timers, no shared phase
    coil_chopper u_coil_a
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .drv_en(s_q.ctrl.drv_en),
        .const_off(const_off),
        .fast_len(fast_len),
        .slow_len(s_q.ctrl.slow_decay_time),
        .comp_dis(s_q.ctrl.comp_dis),
        .rnd(rnd_a),
        .standstill(motor_standstill),
        .cin(coil_a_in),
        .cout(coil_a_out)
    );

    coil_chopper u_coil_b
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .drv_en(s_q.ctrl.drv_en),
        .const_off(const_off),
        .fast_len(fast_len),
        .slow_len(s_q.ctrl.slow_decay_time),
        .comp_dis(s_q.ctrl.comp_dis),
        .rnd(rnd_b),
        .standstill(motor_standstill),
        .cin(coil_b_in),
        .cout(coil_b_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // diagnostic word

    // open load feeds only this word and the interrupt, never the bridges
    always_comb
    begin
        diag.overtemp_prewarn_flag = temp_prewarn;
        diag.overtemp_shutdown_flag = s_q.hot_latch;
        diag.short_ground_flag_coil_a = coil_a_out.short_flag;
        diag.short_ground_flag_coil_b = coil_b_out.short_flag;
        diag.open_load_a = coil_a_out.open_load;
        diag.open_load_b = coil_b_out.open_load;
        diag.bridge_on_a = coil_a_out.bridge_en;
        diag.bridge_on_b = coil_b_out.bridge_en;
        diag.const_off_active = const_off;
    end

    // a flag turning on is an event
    assign ev_now = diag[5:0];
    assign ev_rise = ev_now & ~s_q.ev_prev;

    // bus handshake accepts a transfer only when the bus is ready
    assign addr_phase = hsel && hready && htrans[1];

    // write-one-to-clear mask, only in a write data phase to the status word
    assign w1c = (s_q.pend && s_q.wr && s_q.addr == `ADDR_IRQ_STAT) ? hwdata[5:0] : `EV_RST;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_d = s_q;
        s_d.hresp = 1'b0;
        s_d.ev_prev = ev_now;

        // overtemp latch: shutdown sets, cool-down below pre-warning clears
        if (!temp_prewarn)
            s_d.hot_latch = 1'b0;
        if (temp_shutdown)
            s_d.hot_latch = 1'b1;

        // bus: address phase, then one wait cycle that does the access
        if (s_q.pend)
        begin
            s_d.pend = 1'b0;
            s_d.hreadyout = 1'b1;
            if (s_q.wr)
            begin
                if (s_q.addr == `ADDR_CTRL)
                    s_d.ctrl = ctrl_t'(hwdata[15:0]);
                else if (s_q.addr == `ADDR_IRQ_MASK)
                    s_d.mask = hwdata[5:0];
            end
            else
            begin
                if (s_q.addr == `ADDR_CTRL)
                    s_d.hrdata = 32'(s_q.ctrl);
                else if (s_q.addr == `ADDR_DIAG)
                    s_d.hrdata = 32'(diag);
                else if (s_q.addr == `ADDR_IRQ_STAT)
                    s_d.hrdata = 32'(s_q.stat);
                else if (s_q.addr == `ADDR_IRQ_MASK)
                    s_d.hrdata = 32'(s_q.mask);
                else
                    s_d.hrdata = `WORD_ZERO;
            end
        end
        else if (addr_phase)
        begin
            s_d.pend = 1'b1;
            s_d.hreadyout = 1'b0;
            s_d.addr = haddr[11:0];
            s_d.wr = hwrite;
        end

        // sticky status: a new event beats a clear in the same cycle
        s_d.stat = (s_q.stat & ~w1c) | ev_rise;

        // level interrupt from the values about to be stored
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
            s_q.ctrl <= ctrl_t'(`CTRL_RST);
            s_q.hreadyout <= 1'b1;
            s_q.hrdata <= `WORD_ZERO;
        end
        else
            s_q <= s_d;
    end

    // outputs straight from the state register
    assign hrdata = s_q.hrdata;
    assign hreadyout = s_q.hreadyout;
    assign hresp = s_q.hresp;
    assign irq = s_q.irq;

endmodule // chop_top

// ### rtl/coil_chopper.sv
// Purpose: on / fast decay / slow decay sequencer and protection of one coil
// Assumes: comparator and short inputs synchronous to hclk
// Notes: outputs are registered; one instance per coil
`timescale 1ns/1ps
`include "chop_map.svh"
module coil_chopper
    import chop_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic drv_en,
    input wire logic const_off,
    input wire logic [3:0] fast_len,
    input wire logic [3:0] slow_len,
    input wire logic comp_dis,
    input wire logic [3:0] rnd,
    input wire logic standstill,
    input wire coil_in_t cin,
    output coil_out_t cout
);
    coil_state_t s_q;
    coil_state_t s_d;
    logic [9:0] slow_load;
    logic [9:0] fast_load;

    // off time with optional random stretch
    assign slow_load = (10'(slow_len) << `DECAY_UNIT_SH) + `SLOW_BASE + 10'(rnd);
    assign fast_load = 10'(fast_len) << `DECAY_UNIT_SH;

    always_comb
    begin
        s_d = s_q;
        case (s_q.phase)
            PH_OFF:
            begin
                if (run && !s_q.out.short_flag)
                begin
                    s_d.phase = PH_ON;
                    s_d.cnt = `CNT_ZERO;
                end
            end
            PH_ON:
            begin
                if (s_q.cnt != `CNT_MAX)
                    s_d.cnt = s_q.cnt + `CNT_ONE;
                if (cin.short_evt)
                begin
                    // retry through a slow decay before giving up
                    if (s_q.tries == `SHORT_RETRIES)
                    begin
                        s_d.out.short_flag = 1'b1;
                        s_d.phase = PH_OFF;
                    end
                    else
                    begin
                        s_d.tries = s_q.tries + 2'h1;
                        s_d.phase = PH_SLOW;
                        s_d.cnt = slow_load;
                    end
                end
                else if (cin.cmp_peak)
                begin
                    // comparator ends the on phase
                    s_d.tries = `TRIES_ZERO;
                    s_d.out.open_load = 1'b0;
                    if (const_off && fast_len != 4'h0)
                    begin
                        s_d.phase = PH_FAST;
                        s_d.cnt = fast_load;
                    end
                    else
                    begin
                        s_d.phase = PH_SLOW;
                        s_d.cnt = slow_load;
                    end
                end
                // at or beyond the limit, so a long on phase begun in standstill is still judged later
                else if (s_q.cnt >= 10'(`OPEN_LOAD_CYC) && !standstill)
                    s_d.out.open_load = 1'b1;
            end
            PH_FAST:
            begin
                s_d.cnt = s_q.cnt - `CNT_ONE;
                if (s_q.cnt <= `CNT_ONE || (!comp_dis && cin.cmp_neg))
                begin
                    s_d.phase = PH_SLOW;
                    s_d.cnt = slow_load;
                end
            end
            default:
            begin
                s_d.cnt = s_q.cnt - `CNT_ONE;
                if (s_q.cnt <= `CNT_ONE)
                begin
                    s_d.phase = PH_ON;
                    s_d.cnt = `CNT_ZERO;
                end
            end
        endcase
        // overtemp or disable stops the bridge at once
        if (!run)
            s_d.phase = PH_OFF;
        // latched short only clears by dropping the enable
        if (!drv_en)
        begin
            s_d.out.short_flag = 1'b0;
            s_d.tries = `TRIES_ZERO;
        end
        s_d.out.bridge_en = s_d.phase != PH_OFF;
        s_d.out.drive_on = s_d.phase == PH_ON;
        s_d.out.fast_decay = s_d.phase == PH_FAST;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign cout = s_q.out;
endmodule // coil_chopper

// ### rtl/rand_lfsr.sv
// Purpose: free-running pseudo-random source for off-time modulation
// Assumes: one step per clock
// Notes: 8-bit fibonacci register, never reaches all zeros
`timescale 1ns/1ps
`include "chop_map.svh"
module rand_lfsr
    import chop_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    output logic [7:0] rnd
);
    lfsr_state_t s_q;
    lfsr_state_t s_d;

    // shift in the parity of the tapped bits
    always_comb
    begin
        s_d = s_q;
        s_d.sr = {s_q.sr[6:0], ^(s_q.sr & `LFSR_TAPS)};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '{sr: `LFSR_SEED};
        else
            s_q <= s_d;
    end

    assign rnd = s_q.sr;
endmodule // rand_lfsr

// ### shared/chop_map.svh
// Purpose: addresses, reset values and timing counts of the decay/diagnostic block
// Assumes: 40 MHz hclk, AHB-Lite word registers
// Notes: definitions only
`ifndef CHOP_MAP_SVH
`define CHOP_MAP_SVH

// register byte offsets (low 12 address bits decoded)
`define ADDR_CTRL 12'h000
`define ADDR_DIAG 12'h004
`define ADDR_IRQ_STAT 12'h008
`define ADDR_IRQ_MASK 12'h00C

// reset values
`define CTRL_RST 16'h0000
`define EV_RST 6'h00
`define WORD_ZERO 32'h0000_0000

// decay timing: units of 32 clocks, slow decay plus a fixed 12 clock base
`define DECAY_UNIT_SH 5
`define SLOW_BASE 10'h00C
`define CNT_ONE 10'h001
`define CNT_ZERO 10'h000
`define CNT_MAX 10'h3FF

// open load: on phase longer than this means target current unreachable
`define CLK_NS 25
`define OPEN_LOAD_NS 10000
`define OPEN_LOAD_CYC ((`OPEN_LOAD_NS + `CLK_NS - 1) / `CLK_NS)

// short detection: first hit plus this many retries before latch-off
`define SHORT_RETRIES 2'h3
`define TRIES_ZERO 2'h0

// pseudo-random generator
`define LFSR_SEED 8'hA5
`define LFSR_TAPS 8'hB8

`endif

// ### shared/chop_pkg.sv
// Purpose: types shared by the decay/diagnostic block
// Assumes: chop_map.svh holds the numbers
// Notes: struct bit order is the register bit order, msb first
package chop_pkg;

    // control register, bits 15..0
    typedef struct packed {
        logic drv_en;
        logic mode_sel;
        logic rand_en;
        logic comp_dis;
        logic fast_decay_top_bit;
        logic [3:0] hyst_end_field;
        logic [2:0] hyst_start_field;
        logic [3:0] slow_decay_time;
    } ctrl_t;

    // driver_diag_word, bits 8..0; bits 5..0 are the interrupt events
    typedef struct packed {
        logic const_off_active;
        logic bridge_on_b;
        logic bridge_on_a;
        logic open_load_b;
        logic open_load_a;
        logic short_ground_flag_coil_b;
        logic short_ground_flag_coil_a;
        logic overtemp_shutdown_flag;
        logic overtemp_prewarn_flag;
    } diag_t;

    // from the coil bridge and comparators
    typedef struct packed {
        logic cmp_peak;
        logic cmp_neg;
        logic short_evt;
    } coil_in_t;

    // to the coil bridge, plus the coil flags
    typedef struct packed {
        logic bridge_en;
        logic drive_on;
        logic fast_decay;
        logic short_flag;
        logic open_load;
    } coil_out_t;

    typedef enum logic [1:0] {
        PH_OFF = 2'b00,
        PH_ON = 2'b01,
        PH_FAST = 2'b10,
        PH_SLOW = 2'b11
    } coil_phase_t;

    typedef struct packed {
        coil_phase_t phase;
        logic [9:0] cnt;
        logic [1:0] tries;
        coil_out_t out;
    } coil_state_t;

    typedef struct packed {
        logic [7:0] sr;
    } lfsr_state_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [5:0] stat;
        logic [5:0] mask;
        logic [5:0] ev_prev;
        logic hot_latch;
        logic [11:0] addr;
        logic wr;
        logic pend;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic irq;
    } top_state_t;

endpackage

// ### test/chop_top_monitor.sv
// Purpose: port-level checks of the decay and diagnostic block
// Assumes: coil a carries the per-coil checks, coil b is built alike
// Notes: bound into every chop_top instance
`timescale 1ns/1ps
module chop_top_monitor
    import chop_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic temp_shutdown,
    input wire logic motor_standstill,
    input wire coil_in_t coil_a_in,
    input wire coil_out_t coil_a_out,
    input wire coil_out_t coil_b_out,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////
    // bus answer: exactly one wait state, always okay
    property p_wait;
        hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state not one cycle");
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");

    ////////////////////////////////////////////////////////////////
    // protection: latch lag is two edges, input then chopper register
    property p_hot_off;
        temp_shutdown |-> ##2 !(coil_a_out.bridge_en || coil_b_out.bridge_en);
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("bridge on in shutdown");
    property p_short_off;
        coil_a_out.short_flag |-> !coil_a_out.bridge_en;
    endproperty
    a_short_off: assert property (p_short_off) else $error("bridge on with short");
    property p_short_cause;
        $rose(coil_a_out.short_flag) |-> $past(coil_a_in.short_evt) || $past(coil_a_in.short_evt, 2);
    endproperty
    a_short_cause: assert property (p_short_cause) else $error("short flag without hit");

    ////////////////////////////////////////////////////////////////
    // phase order and open load
    property p_fast_cause;
        $rose(coil_a_out.fast_decay) |-> $past(coil_a_in.cmp_peak);
    endproperty
    a_fast_cause: assert property (p_fast_cause) else $error("fast decay without peak");
    property p_excl;
        !(coil_a_out.drive_on && coil_a_out.fast_decay);
    endproperty
    a_excl: assert property (p_excl) else $error("drive and fast decay together");
    property p_ol_stand;
        motor_standstill && !coil_a_out.open_load |=> !coil_a_out.open_load;
    endproperty
    a_ol_stand: assert property (p_ol_stand) else $error("open load in standstill");
    property p_ol_noact;
        $rose(coil_a_out.open_load) |-> coil_a_out.drive_on && coil_a_out.bridge_en;
    endproperty
    a_ol_noact: assert property (p_ol_noact) else $error("open load acted on bridge");

    // main scenarios reached
    c_short: cover property ($rose(coil_a_out.short_flag));
    c_ol: cover property ($rose(coil_a_out.open_load));
    c_fast: cover property ($rose(coil_a_out.fast_decay));
    c_irq: cover property ($rose(irq));
endmodule // chop_top_monitor

bind chop_top chop_top_monitor i_chop_top_monitor (.hclk, .hresetn, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .temp_shutdown, .motor_standstill, .coil_a_in, .coil_a_out, .coil_b_out, .irq);

// ### test/chopper_decay_and_driver_diag_bench.sv
// Purpose: self-checking run of chop_top over its bus and coil pins
// Assumes: design answers each access after one wait state
// Notes: decay lengths are counted in sampled clock edges
`timescale 1ns/1ps
`include "chop_map.svh"
module chopper_decay_and_driver_diag_bench
    import chop_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, x;
    logic hreadyout, hresp, irq, p, ok, v;
    logic temp_prewarn = 1'b0, temp_shutdown = 1'b0, fullstep_load_mode = 1'b0, motor_standstill = 1'b0;
    logic [9:0] pk_a = 10'h005, pk_b = 10'h009, ng = 10'h003;
    logic sh_a = 1'b0;
    coil_in_t coil_a_in, coil_b_in;
    coil_out_t coil_a_out, coil_b_out;
    int failures = 0, checks_done = 0, f, s, k, fa, fb;

    chop_top i_chop_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .temp_prewarn(temp_prewarn), .temp_shutdown(temp_shutdown),
        .fullstep_load_mode(fullstep_load_mode), .motor_standstill(motor_standstill),
        .coil_a_in(coil_a_in), .coil_b_in(coil_b_in), .coil_a_out(coil_a_out), .coil_b_out(coil_b_out),
        .irq(irq));
    coil_model m_coil_a (.hclk(hclk), .cout(coil_a_out), .peak_dly(pk_a), .neg_dly(ng), .short_on(sh_a),
        .cin(coil_a_in));
    coil_model m_coil_b (.hclk(hclk), .cout(coil_b_out), .peak_dly(pk_b), .neg_dly(ng), .short_on(1'b0),
        .cin(coil_b_in));

    ////////////////////////////////////////////////////////////////
    // 40 MHz clock; watchdog far beyond the few thousand cycles needed
    initial forever #12.5 hclk = ~hclk;
    initial
    begin
        #(25 * 60000);
        failures++;
        end_sim();
    end

    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // single word transfer; address held until ready, data until ready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h00000, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // one full fast decay and the slow decay behind it, coil a
    task automatic meas(output int fl, output int sl);
        fl = 0;
        sl = 0;
        while (coil_a_out.fast_decay === 1'b1) @(posedge hclk);
        while (coil_a_out.fast_decay !== 1'b1) @(posedge hclk);
        for (; coil_a_out.fast_decay === 1'b1; fl++) @(posedge hclk);
        for (; coil_a_out.drive_on !== 1'b1; sl++) @(posedge hclk);
    endtask

    task automatic watch(input int n);
        // let a fast decay begun under the old setting run out first
        repeat (40) @(posedge hclk);
        fa = 0;
        fb = 0;
        repeat (n)
        begin
            @(posedge hclk);
            fa += coil_a_out.fast_decay;
            fb += coil_b_out.fast_decay;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({irq, coil_a_out, coil_b_out}, 0);
        for (int a = 0; a < 20; a += 4)
        begin
            bus(1'b0, a[11:0], 0, x);
            chk(x, 0);
        end
        wr(`ADDR_IRQ_MASK, 32'hFFFF_FFFF);
        bus(1'b0, `ADDR_IRQ_MASK, 0, x);
        chk(x, 32'h0000_003F);
        wr(`ADDR_IRQ_MASK, 0);
        // fixed lengths, comparator ignored while disabled
        wr(`ADDR_CTRL, 32'h0000_D011);
        meas(f, s);
        chk(f, 32);
        chk(s, 44);
        wr(`ADDR_CTRL, 32'h0000_D802);
        meas(f, s);
        chk(f, 256);
        chk(s, 76);
        wr(`ADDR_CTRL, 32'h0000_C011);
        meas(f, s);
        chk(f > 0 && f < 10, 1);
        // random off time stays within its sixteen-cycle spread
        wr(`ADDR_CTRL, 32'h0000_F011);
        ok = 1'b1;
        v = 1'b0;
        repeat (6)
        begin
            meas(f, s);
            ok &= s >= 44 && s <= 59;
            v |= s != 44;
        end
        chk({ok, v}, 2'b11);
        bus(1'b0, `ADDR_DIAG, 0, x);
        chk(x[8], 1);
        watch(300);
        chk(fa > 0 && fb > 0, 1);
        // mode zero, then forced by fullstep, then zero fast length
        wr(`ADDR_CTRL, 32'h0000_8011);
        watch(300);
        bus(1'b0, `ADDR_DIAG, 0, x);
        chk({fa[30:0], x[8]}, 0);
        fullstep_load_mode <= 1'b1;
        watch(300);
        bus(1'b0, `ADDR_DIAG, 0, x);
        chk({fa > 0, x[8]}, 2'b11);
        fullstep_load_mode <= 1'b0;
        wr(`ADDR_CTRL, 32'h0000_C001);
        watch(300);
        chk(fa, 0);
        // open coil: ignored in standstill, flagged while running
        wr(`ADDR_CTRL, 32'h0000_C011);
        pk_a <= 10'h000;
        motor_standstill <= 1'b1;
        repeat (600) @(posedge hclk);
        chk(coil_a_out.open_load, 0);
        motor_standstill <= 1'b0;
        repeat (450) @(posedge hclk);
        chk({coil_a_out.open_load, coil_a_out.drive_on}, 2'b11);
        bus(1'b0, `ADDR_DIAG, 0, x);
        chk(x[4], 1);
        pk_a <= 10'h014;
        repeat (20) @(posedge hclk);
        chk(coil_a_out.open_load, 0);
        wr(`ADDR_IRQ_STAT, 32'h0000_003F);
        // short: three retries, then coil a alone latched off
        wr(`ADDR_CTRL, 32'h0000_4011);
        sh_a <= 1'b1;
        wr(`ADDR_CTRL, 32'h0000_C011);
        k = 0;
        p = 1'b0;
        while (coil_a_out.short_flag !== 1'b1)
        begin
            @(posedge hclk);
            if (coil_a_out.drive_on === 1'b1 && !p)
                k++;
            p = coil_a_out.drive_on;
        end
        chk(k, 4);
        sh_a <= 1'b0;
        repeat (100) @(posedge hclk);
        chk({coil_a_out.bridge_en, coil_a_out.short_flag, coil_b_out.bridge_en}, 3'b011);
        bus(1'b0, `ADDR_IRQ_STAT, 0, x);
        chk({x[30:0], irq}, 32'h0000_0008);
        wr(`ADDR_IRQ_MASK, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        chk(irq, 1);
        wr(`ADDR_IRQ_STAT, 32'h0000_0004);
        repeat (2) @(posedge hclk);
        chk(irq, 0);
        wr(`ADDR_CTRL, 32'h0000_4011);
        wr(`ADDR_CTRL, 32'h0000_C011);
        repeat (5) @(posedge hclk);
        chk({coil_a_out.short_flag, coil_a_out.bridge_en}, 2'b01);
        // temperature: shutdown holds until the warning clears
        temp_prewarn <= 1'b1;
        repeat (3) @(posedge hclk);
        temp_shutdown <= 1'b1;
        repeat (5) @(posedge hclk);
        bus(1'b0, `ADDR_DIAG, 0, x);
        chk({x[1:0], coil_a_out.bridge_en, coil_b_out.bridge_en}, 4'hC);
        temp_shutdown <= 1'b0;
        repeat (100) @(posedge hclk);
        chk(coil_a_out.bridge_en, 0);
        temp_prewarn <= 1'b0;
        repeat (5) @(posedge hclk);
        chk(coil_a_out.bridge_en, 1);
        end_sim();
    end
endmodule // chopper_decay_and_driver_diag_bench

// ### test/coil_model.sv
// Purpose: behavioural bridge and comparators of one coil
// Assumes: changes just after hclk rises
// Notes: peak_dly 0 models an open coil; short_on hits every on phase
`timescale 1ns/1ps
module coil_model
    import chop_pkg::*;
(
    input wire logic hclk,
    input wire coil_out_t cout,
    input wire logic [9:0] peak_dly,
    input wire logic [9:0] neg_dly,
    input wire logic short_on,
    output coil_in_t cin
);
    logic [1:0] ph_q = 2'h0;
    logic [9:0] n_q = 10'h000;
    logic [9:0] n_d;
    initial cin = '0;

    // count cycles in the present phase, saturating; answer from the fresh count, not the last phase's
    always @(posedge hclk)
    begin
        n_d = ({cout.drive_on, cout.fast_decay} != ph_q) ? 10'h000 : (n_q == 10'h3FF) ? n_q : n_q + 10'h001;
        ph_q <= {cout.drive_on, cout.fast_decay};
        n_q <= n_d;
        cin.cmp_peak <= cout.drive_on && peak_dly != 10'h000 && n_d >= peak_dly;
        cin.cmp_neg <= cout.fast_decay && neg_dly != 10'h000 && n_d >= neg_dly;
        cin.short_evt <= cout.drive_on && short_on;
    end
endmodule // coil_model
